// ---- hdl/gcsr_pkg.sv ----
// Purpose: Shared constants and carrier types for the pin configuration and shadow bank.
// Assumes: Byte-wide registers on a plain strobe port, one 40 MHz clock.
// Notes:   Offsets are the printed byte offsets of the runtime bank.
`default_nettype none
package gcsr_pkg;
    localparam int          NUM_PINS        = 7;
    localparam int          NUM_SERIAL      = 4;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  OFF_FLOPPY_RATE = 8'h1F;
    localparam logic [7:0]  OFF_SERIAL1     = 8'h20;
    localparam logic [7:0]  OFF_SERIAL2     = 8'h21;
    localparam logic [7:0]  OFF_SERIAL3     = 8'h22;
    localparam logic [7:0]  OFF_PIN_1_0     = 8'h23;
    localparam logic [7:0]  OFF_PIN_1_1     = 8'h24;
    localparam logic [7:0]  OFF_PIN_1_2     = 8'h25;
    localparam logic [7:0]  OFF_PIN_1_3     = 8'h26;
    localparam logic [7:0]  OFF_PIN_1_4     = 8'h27;
    localparam logic [7:0]  OFF_SERIAL4     = 8'h28;
    localparam logic [7:0]  OFF_PIN_1_5     = 8'h29;
    localparam logic [7:0]  OFF_PIN_1_6     = 8'h2A;
    // Pin configuration fields.
    localparam int          CFG_DIR_BIT     = 0;
    localparam int          CFG_INV_BIT     = 1;
    localparam int          CFG_ALT_BIT     = 2;
    localparam int          CFG_OD_BIT      = 7;
    localparam logic [7:0]  CFG_RESET       = 8'h01;
    localparam logic [7:0]  CFG_MASK_MULTI  = 8'h87;
    localparam logic [7:0]  CFG_MASK_TWO    = 8'h83;
    // Shadow layouts; reserved bits are cleared by these masks.
    localparam logic [7:0]  FLOPPY_MASK     = 8'hDF;
    localparam logic [7:0]  FIFO_MASK       = 8'hCF;
    localparam logic [7:0]  SHADOW_RESET    = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
    // Alternate-function signal index within a pin's route (pins 1.0 to 1.5).
    localparam int          ALT_RXD         = 0;
    localparam int          ALT_TXD         = 1;
    localparam int          ALT_DCD         = 2;
    localparam int          ALT_RI          = 3;
    localparam int          ALT_DSR         = 4;
    localparam int          ALT_DTR         = 5;

    typedef struct packed {
        logic               wr;
        logic               rd;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
    } gcsr_bus_s;

    typedef struct packed {
        logic               out;
        logic               oe;
    } gcsr_pin_drv_s;
endpackage : gcsr_pkg
`default_nettype wire

// ---- hdl/gcsr_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to core_clk_in.
// Notes:   The output changes only when stages two and three agree.
`default_nettype none
module gcsr_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } gcsr_sync_state_s;

    gcsr_sync_state_s st;
    gcsr_sync_state_s next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.q;
endmodule : gcsr_sync
`default_nettype wire

// ---- hdl/gcsr_pin_cell.sv ----
// Purpose: One general-purpose pin: direction, polarity and driver type.
// Assumes: Pin input already synchronised; inversion applies both ways.
// Notes:   Open drain only ever drives low and releases for a one.
`default_nettype none
module gcsr_pin_cell (
    input  wire logic                   dir_in,
    input  wire logic                   inv_in,
    input  wire logic                   od_in,
    input  wire logic                   value_in,
    input  wire logic                   pin_sync_in,
    output gcsr_pkg::gcsr_pin_drv_s     drv_out,
    output logic                        value_out
);
    logic pin_level;

    always_comb
    begin
        pin_level = value_in ^ inv_in;
        if (dir_in)
        begin
            drv_out.out = 1'b0;
            drv_out.oe  = 1'b0;
        end
        else if (od_in)
        begin
            drv_out.out = 1'b0;
            drv_out.oe  = ~pin_level;
        end
        else
        begin
            drv_out.out = pin_level;
            drv_out.oe  = 1'b1;
        end
        value_out = pin_sync_in ^ inv_in;
    end
endmodule : gcsr_pin_cell
`default_nettype wire

// ---- hdl/gcsr_bank.sv ----
// Purpose: Pin configuration registers for pins 1.0 to 1.6 and read-only shadows.
// Assumes: Shadow sources are the live values of the write-only controls elsewhere.
// Notes:   Read data stand for exactly one cycle after the read strobe.
`default_nettype none
// Function
// - Configuration bit 0 set makes the pin an input; clear drives it out.
// - Configuration bit 1 set inverts the value between pin and register.
// - Configuration bit 7 set gives open drain, clear gives push-pull output.
// - Multi-port: bit 2 routes pins 1.0-1.5 to the third serial port signals.
// - Floppy rate shadow at 0x1F is read-only with bit 5 reserved.
// - FIFO shadows report enable, resets and DMA mode; bits 5:4 reserved.
// - FIFO shadows report receive trigger level in bits 7:6.
// - Third and fourth FIFO shadows exist only on four-port variants.
module gcsr_bank #(
    parameter bit MULTI_PORT = 1'b1
) (
    input  wire logic                                   core_clk_in,
    input  wire logic                                   rst_n_in,
    input  wire logic [gcsr_pkg::ADDR_W-1:0]            reg_addr_in,
    input  wire logic [gcsr_pkg::DATA_W-1:0]            reg_wdata_in,
    input  wire logic                                   reg_wr_in,
    input  wire logic                                   reg_rd_in,
    output logic      [gcsr_pkg::DATA_W-1:0]            reg_rdata_out,
    input  wire logic [7:0]                             floppy_rate_ctrl_in,
    input  wire logic [gcsr_pkg::NUM_SERIAL*8-1:0]      serial_fifo_ctrl_in,
    input  wire logic [gcsr_pkg::NUM_PINS-1:0]          pin_in,
    output logic      [gcsr_pkg::NUM_PINS-1:0]          pin_out,
    output logic      [gcsr_pkg::NUM_PINS-1:0]          pin_oe_out,
    input  wire logic [gcsr_pkg::NUM_PINS-1:0]          gpio_value_in,
    output logic      [gcsr_pkg::NUM_PINS-1:0]          gpio_value_out,
    input  wire logic                                   port3_transmit_data_in,
    input  wire logic                                   port3_terminal_ready_n_in,
    output logic                                        port3_receive_data_out,
    output logic                                        port3_carrier_detect_n_out,
    output logic                                        port3_ring_indicate_n_out,
    output logic                                        port3_set_ready_n_out
);
    localparam int NP = gcsr_pkg::NUM_PINS;

    typedef struct packed {
        logic [NP-1:0][7:0]  cfg;
        logic [7:0]          rdata;
        logic [NP-1:0]       pin_o;
        logic [NP-1:0]       pin_oe;
        logic [NP-1:0]       gval;
        logic [3:0]          port3_in;
    } gcsr_bank_state_s;

    gcsr_bank_state_s              st;
    gcsr_bank_state_s              next_st;
    gcsr_pkg::gcsr_bus_s           bus;
    gcsr_pkg::gcsr_pin_drv_s [NP-1:0] drv;
    logic [NP-1:0]                 pin_sync;
    logic [NP-1:0]                 cell_value;
    logic [NP-1:0]                 alt_sel;
    logic [NP-1:0]                 drive_value;

    // Maps an offset to a pin index, or NP when the offset is no pin register.
    function automatic int pin_index(input logic [7:0] a);
        case (a)
            gcsr_pkg::OFF_PIN_1_0: pin_index = 0;
            gcsr_pkg::OFF_PIN_1_1: pin_index = 1;
            gcsr_pkg::OFF_PIN_1_2: pin_index = 2;
            gcsr_pkg::OFF_PIN_1_3: pin_index = 3;
            gcsr_pkg::OFF_PIN_1_4: pin_index = 4;
            gcsr_pkg::OFF_PIN_1_5: pin_index = 5;
            gcsr_pkg::OFF_PIN_1_6: pin_index = 6;
            default:               pin_index = NP;
        endcase
    endfunction : pin_index

    function automatic logic [7:0] fifo_view(input logic [7:0] v);
        fifo_view = v & gcsr_pkg::FIFO_MASK;
    endfunction : fifo_view

    function automatic logic [7:0] cfg_mask();
        cfg_mask = MULTI_PORT ? gcsr_pkg::CFG_MASK_MULTI : gcsr_pkg::CFG_MASK_TWO;
    endfunction : cfg_mask

    always_comb
    begin
        bus.wr    = reg_wr_in;
        bus.rd    = reg_rd_in;
        bus.addr  = reg_addr_in;
        bus.wdata = reg_wdata_in;
    end

    gcsr_sync #(
        .W (NP)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .async_in    (pin_in),
        .sync_out    (pin_sync)
    );

    generate
        for (genvar g = 0; g < NP; g++)
        begin : g_pin
            // Pin 1.6 has no third-port function in this slice.
            if (g < 6)
            begin : g_alt
                assign alt_sel[g] = MULTI_PORT && st.cfg[g][gcsr_pkg::CFG_ALT_BIT];
            end
            else
            begin : g_plain
                assign alt_sel[g] = 1'b0;
            end
            gcsr_pin_cell u_cell (
                .dir_in      (st.cfg[g][gcsr_pkg::CFG_DIR_BIT]),
                .inv_in      (st.cfg[g][gcsr_pkg::CFG_INV_BIT]),
                .od_in       (st.cfg[g][gcsr_pkg::CFG_OD_BIT]),
                .value_in    (drive_value[g]),
                .pin_sync_in (pin_sync[g]),
                .drv_out     (drv[g]),
                .value_out   (cell_value[g])
            );
        end
    endgenerate

    // Routed transmit-side signals replace the GPIO value on their pins.
    always_comb
    begin
        drive_value = gpio_value_in;
        if (alt_sel[gcsr_pkg::ALT_TXD])
        begin
            drive_value[gcsr_pkg::ALT_TXD] = port3_transmit_data_in;
        end
        if (alt_sel[gcsr_pkg::ALT_DTR])
        begin
            drive_value[gcsr_pkg::ALT_DTR] = port3_terminal_ready_n_in;
        end
    end

    always_comb
    begin
        int idx;
        idx     = pin_index(bus.addr);
        next_st = st;
        if (bus.wr && idx < NP)
        begin
            next_st.cfg[idx] = bus.wdata & cfg_mask();
        end
        // Writes to shadow offsets fall through untouched.
        next_st.rdata = gcsr_pkg::READ_UNMAPPED;
        if (bus.rd)
        begin
            if (idx < NP)
            begin
                next_st.rdata = st.cfg[idx];
            end
            else
            begin
                case (bus.addr)
                    gcsr_pkg::OFF_FLOPPY_RATE:
                        next_st.rdata = floppy_rate_ctrl_in & gcsr_pkg::FLOPPY_MASK;
                    gcsr_pkg::OFF_SERIAL1:
                        next_st.rdata = fifo_view(serial_fifo_ctrl_in[7:0]);
                    gcsr_pkg::OFF_SERIAL2:
                        next_st.rdata = fifo_view(serial_fifo_ctrl_in[15:8]);
                    gcsr_pkg::OFF_SERIAL3:
                        next_st.rdata = MULTI_PORT ?
                            fifo_view(serial_fifo_ctrl_in[23:16]) : 8'h00;
                    gcsr_pkg::OFF_SERIAL4:
                        next_st.rdata = MULTI_PORT ?
                            fifo_view(serial_fifo_ctrl_in[31:24]) : 8'h00;
                    default:
                        next_st.rdata = gcsr_pkg::READ_UNMAPPED;
                endcase
            end
        end
        for (int i = 0; i < NP; i++)
        begin
            next_st.pin_o[i]  = drv[i].out;
            next_st.pin_oe[i] = drv[i].oe;
            next_st.gval[i]   = cell_value[i];
        end
        // Received third-port signals idle high when their pin is plain GPIO.
        next_st.port3_in[0] = alt_sel[gcsr_pkg::ALT_RXD] ? pin_sync[gcsr_pkg::ALT_RXD] : 1'b1;
        next_st.port3_in[1] = alt_sel[gcsr_pkg::ALT_DCD] ? pin_sync[gcsr_pkg::ALT_DCD] : 1'b1;
        next_st.port3_in[2] = alt_sel[gcsr_pkg::ALT_RI]  ? pin_sync[gcsr_pkg::ALT_RI]  : 1'b1;
        next_st.port3_in[3] = alt_sel[gcsr_pkg::ALT_DSR] ? pin_sync[gcsr_pkg::ALT_DSR] : 1'b1;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st.cfg      <= {NP{gcsr_pkg::CFG_RESET}};
            st.rdata    <= gcsr_pkg::SHADOW_RESET;
            st.pin_o    <= '0;
            st.pin_oe   <= '0;
            st.gval     <= '0;
            st.port3_in <= 4'hF;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_out              = st.rdata;
    assign pin_out                    = st.pin_o;
    assign pin_oe_out                 = st.pin_oe;
    assign gpio_value_out             = st.gval;
    assign port3_receive_data_out     = st.port3_in[0];
    assign port3_carrier_detect_n_out = st.port3_in[1];
    assign port3_ring_indicate_n_out  = st.port3_in[2];
    assign port3_set_ready_n_out      = st.port3_in[3];
endmodule : gcsr_bank
`default_nettype wire

// ---- bench/gcsr_monitor.sv ----
// Purpose: Bound checker for the pin configuration and shadow bank.
// Assumes: One clock domain; bench holds gpio and transmit inputs steady around writes.
// Notes:   Pin checks look two edges after a configuration write is taken.
`default_nettype none
module gcsr_monitor #(
    parameter bit MULTI_PORT = 1'b1
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_rdata_out,
    input  wire logic [7:0]  floppy_rate_ctrl_in,
    input  wire logic [31:0] serial_fifo_ctrl_in,
    input  wire logic [6:0]  gpio_value_in,
    input  wire logic [6:0]  pin_out,
    input  wire logic [6:0]  pin_oe_out,
    input  wire logic        port3_transmit_data_in
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(logic [7:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    // The pin result depends on inputs one edge later, so they must not move meanwhile.
    sequence s_cfg(logic [7:0] d, logic [7:0] a);
        reg_wr_in && reg_addr_in == a && reg_wdata_in == d
            ##1 ($stable(gpio_value_in) && $stable(port3_transmit_data_in)) [*2];
    endsequence
    property p_floppy;
        s_rd(8'h1F) |=> reg_rdata_out == ($past(floppy_rate_ctrl_in) & 8'hDF);
    endproperty
    property p_fifo1;
        s_rd(8'h20) |=> reg_rdata_out == ($past(serial_fifo_ctrl_in[7:0]) & 8'hCF);
    endproperty
    property p_fifo4;
        s_rd(8'h28) |=> reg_rdata_out ==
            (MULTI_PORT ? ($past(serial_fifo_ctrl_in[31:24]) & 8'hCF) : 8'h00);
    endproperty
    property p_unmapped;
        reg_rd_in && (reg_addr_in < 8'h1F || reg_addr_in > 8'h2A) |=> reg_rdata_out == 8'h00;
    endproperty
    property p_out;
        s_cfg(8'h00, 8'h23) |-> pin_oe_out[0] && pin_out[0] == gpio_value_in[0];
    endproperty
    property p_in;
        s_cfg(8'h01, 8'h23) |-> !pin_oe_out[0];
    endproperty
    property p_inv;
        s_cfg(8'h02, 8'h23) |-> pin_oe_out[0] && pin_out[0] == !gpio_value_in[0];
    endproperty
    property p_od;
        s_cfg(8'h80, 8'h23) |-> pin_oe_out[0] == !gpio_value_in[0];
    endproperty
    // Without the third-port route the bit is reserved, so the pin stays plain GPIO.
    property p_alt;
        s_cfg(8'h04, 8'h24) |-> pin_oe_out[1] &&
            pin_out[1] == (MULTI_PORT ? port3_transmit_data_in : gpio_value_in[1]);
    endproperty
    a_floppy: assert property (p_floppy)
        else $error("floppy shadow read wrong");
    a_fifo1: assert property (p_fifo1)
        else $error("fifo shadow read wrong");
    a_fifo4: assert property (p_fifo4)
        else $error("fourth fifo shadow read wrong");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_out: assert property (p_out)
        else $error("output pin not driven");
    a_in: assert property (p_in)
        else $error("input pin driven");
    a_inv: assert property (p_inv)
        else $error("inverted output wrong");
    a_od: assert property (p_od)
        else $error("open drain enable wrong");
    a_alt: assert property (p_alt)
        else $error("routed transmit wrong");
endmodule : gcsr_monitor
bind gcsr_bank gcsr_monitor #(.MULTI_PORT(MULTI_PORT)) u_monitor (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .floppy_rate_ctrl_in(floppy_rate_ctrl_in),
    .serial_fifo_ctrl_in(serial_fifo_ctrl_in), .gpio_value_in(gpio_value_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .port3_transmit_data_in(port3_transmit_data_in));
`default_nettype wire

// ---- bench/gcsr_board_model.sv ----
// Purpose: Board side of the seven general-purpose pin wires.
// Assumes: Every wire has a pull-up; the board drives only where enabled.
// Notes:   The device wins while it drives, so contention is not modelled.
`default_nettype none
module gcsr_board_model (
    input  wire logic [6:0] drive_in,
    input  wire logic [6:0] drive_en_in,
    input  wire logic [6:0] ext_value_in,
    input  wire logic [6:0] ext_en_in,
    output logic      [6:0] level_out
);
    // A released open-drain wire must read high, so the pull-up is the idle level.
    always_comb
    begin
        for (int i = 0; i < 7; i++)
            level_out[i] = drive_en_in[i] ? drive_in[i] : (ext_en_in[i] ? ext_value_in[i] : 1'b1);
    end
endmodule : gcsr_board_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the pin configuration and shadow bank.
// Assumes: Four-port variant, plus a two-port copy on the same bus; read data the cycle after.
// Notes:   Pin input results are sampled eight cycles after a change.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk_in, rst_n_in, reg_wr_in, reg_rd_in;
    logic        port3_transmit_data_in, port3_terminal_ready_n_in;
    logic        port3_receive_data_out, port3_carrier_detect_n_out;
    logic        port3_ring_indicate_n_out, port3_set_ready_n_out;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, floppy_rate_ctrl_in, rdata_two;
    logic [31:0] serial_fifo_ctrl_in;
    logic [6:0]  pin_in, pin_out, pin_oe_out, gpio_value_in, gpio_value_out, ext_val, ext_en;
    int          mismatches = 0, checked = 0, cycles = 0;
    logic [7:0]  pins [7] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2A};
    logic [7:0]  shd [5] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h28};
    logic [7:0]  shx [5] = '{8'h5F, 8'hCF, 8'h0F, 8'hC0, 8'hC3};

    gcsr_bank #(.MULTI_PORT(1'b1)) DUT (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .floppy_rate_ctrl_in(floppy_rate_ctrl_in),
        .serial_fifo_ctrl_in(serial_fifo_ctrl_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .gpio_value_in(gpio_value_in),
        .gpio_value_out(gpio_value_out), .port3_transmit_data_in(port3_transmit_data_in),
        .port3_terminal_ready_n_in(port3_terminal_ready_n_in),
        .port3_receive_data_out(port3_receive_data_out),
        .port3_carrier_detect_n_out(port3_carrier_detect_n_out),
        .port3_ring_indicate_n_out(port3_ring_indicate_n_out),
        .port3_set_ready_n_out(port3_set_ready_n_out));
    gcsr_board_model u_board (.drive_in(pin_out), .drive_en_in(pin_oe_out),
        .ext_value_in(ext_val), .ext_en_in(ext_en), .level_out(pin_in));
    // The two-port copy shares every input; the bench judges only its read data, and the bound checker also judges its pins.
    gcsr_bank #(.MULTI_PORT(1'b0)) DUT_two_port (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata_two), .floppy_rate_ctrl_in(floppy_rate_ctrl_in),
        .serial_fifo_ctrl_in(serial_fifo_ctrl_in), .pin_in(pin_in), .pin_out(),
        .pin_oe_out(), .gpio_value_in(gpio_value_in), .gpio_value_out(),
        .port3_transmit_data_in(port3_transmit_data_in),
        .port3_terminal_ready_n_in(port3_terminal_ready_n_in),
        .port3_receive_data_out(), .port3_carrier_detect_n_out(),
        .port3_ring_indicate_n_out(), .port3_set_ready_n_out());

    initial
    begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(what, exp, reg_rdata_out);
    endtask : rdchk
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : settle
    task automatic t_reset();
        for (int i = 0; i < 7; i++) rdchk(pins[i], 8'h01, "cfg reset");
        chk("oe reset", 8'h00, {1'b0, pin_oe_out});
        $display("test reset done");
    endtask : t_reset
    task automatic t_dir();
        @(posedge core_clk_in);
        gpio_value_in <= 7'h55;
        for (int i = 0; i < 7; i++) wr(pins[i], 8'hFB);
        for (int i = 0; i < 7; i++) rdchk(pins[i], 8'h83, "cfg mask");
        chk("oe input", 8'h00, {1'b0, pin_oe_out});
        for (int i = 0; i < 7; i++) wr(pins[i], 8'h00);
        settle(2);
        chk("oe output", 8'h7F, {1'b0, pin_oe_out});
        chk("push pull", 8'h55, {1'b0, pin_out});
        $display("test direction done");
    endtask : t_dir
    task automatic t_pol_od();
        @(posedge core_clk_in);
        ext_en <= 7'h01;
        ext_val <= 7'h01;
        wr(pins[0], 8'h02);
        settle(2);
        chk("inverted out", 8'h00, {7'h00, pin_out[0]});
        wr(pins[0], 8'h03);
        settle(8);
        chk("inverted in", 8'h00, {7'h00, gpio_value_out[0]});
        wr(pins[0], 8'h01);
        settle(8);
        chk("plain in", 8'h01, {7'h00, gpio_value_out[0]});
        wr(pins[0], 8'h80);
        settle(2);
        chk("od release", 8'h00, {7'h00, pin_oe_out[0]});
        @(posedge core_clk_in);
        gpio_value_in <= 7'h54;
        settle(3);
        chk("od low", 8'h02, {6'h00, pin_oe_out[0], pin_out[0]});
        $display("test polarity and drain done");
    endtask : t_pol_od
    task automatic t_alt();
        @(posedge core_clk_in);
        gpio_value_in <= 7'h20;
        ext_en <= 7'h7F;
        ext_val <= 7'h14;
        port3_transmit_data_in <= 1'b1;
        port3_terminal_ready_n_in <= 1'b0;
        for (int i = 0; i < 6; i++) wr(pins[i], (i == 1 || i == 5) ? 8'h04 : 8'h05);
        settle(8);
        chk("routed in", 8'h05, {4'h0, port3_receive_data_out,
            port3_carrier_detect_n_out, port3_ring_indicate_n_out, port3_set_ready_n_out});
        chk("routed out", 8'h0B, {4'h0, pin_oe_out[5], pin_out[5],
            pin_oe_out[1], pin_out[1]});
        $display("test routing done");
    endtask : t_alt
    task automatic t_shadow();
        @(posedge core_clk_in);
        floppy_rate_ctrl_in <= 8'h7F;
        serial_fifo_ctrl_in <= 32'hC3F03FFF;
        for (int i = 0; i < 5; i++) wr(shd[i], 8'h00);
        wr(8'h30, 8'hAA);
        for (int i = 0; i < 5; i++) rdchk(shd[i], shx[i], "shadow");
        rdchk(8'h30, 8'h00, "unmapped");
        rdchk(8'h1E, 8'h00, "below bank");
        $display("test shadows done");
    endtask : t_shadow
    task automatic t_two_port();
        wr(pins[1], 8'h87);
        rdchk(pins[1], 8'h87, "cfg multi port");
        chk("cfg two port", 8'h83, rdata_two);
        rdchk(8'h22, 8'hC0, "third fifo");
        chk("third fifo two port", 8'h00, rdata_two);
        rdchk(8'h28, 8'hC3, "fourth fifo");
        chk("fourth fifo two port", 8'h00, rdata_two);
        $display("test two-port variant done");
    endtask : t_two_port
    initial
    begin
        {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {floppy_rate_ctrl_in, serial_fifo_ctrl_in, gpio_value_in, ext_val, ext_en} = '0;
        {port3_transmit_data_in, port3_terminal_ready_n_in} = 2'b11;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_dir();
        t_pol_od();
        t_alt();
        t_shadow();
        t_two_port();
        conclude();
    end
endmodule : testbench
`default_nettype wire
